// *** rtl/clock_select_divide.sv ***
// What this block does
// - System clock comes from main crystal, sub crystal or on-chip oscillator.
// - CPU clock is system clock divided by 1, 2, 4, 8 or 16.
// - Divide-by-8 bit forces /8; else field 00 /1, 01 /2, 10 /4, 11 /16.
// - After reset CPU runs from slow on-chip oscillator, undivided.
// - Entering stop mode sets the divide-by-8 bit.
// - Five peripheral clocks: system clock divided by 1, 2, 4, 8, 32.
// - Wait mode with wait-stop bit set halts all peripheral divided clocks.
// - Internal oscillator peripheral clock follows on-chip clock, runs in wait.
// - Fast timer clock only while fast enable set; runs in wait.
// - Fast divided clock is fast oscillator divided by 2 to 9, gated, runs in wait.
// - Slow internal clock only while slow-off bit clear; runs in wait.
// - Divide-by-128 clock from slow internal clock or fast divided clock.
// - Watchdog clock from slow oscillator under protect; never stops then.
// - Fast enable and fast select pick the fast oscillator as on-chip clock.
// - Slow-off clear and fast select clear pick the slow oscillator.
// - High-speed mode: main crystal divided, given its enabling bit settings.
// - Low-speed mode: sub crystal divided, given its enabling bit settings.
// - Internal oscillator timer clock usable when slow on or fast enabled.
//
// Clocks are modelled as one-cycle ticks on mclk; outputs are tick enables.
`timescale 1ns/1ps

module tick_div
	import clkgen_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         tick_in,
	input  wire logic         run,
	input  wire logic [W-1:0] ratio,
	output logic              tick_out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         out_d;

	always_comb begin
		cnt_d = cnt_q;
		out_d = 1'h0;
		if (!run) begin
			cnt_d = '0;
		end else if (tick_in) begin
			if (cnt_q >= ratio - W'(1)) begin
				cnt_d = '0;
				out_d = 1'h1;
			end else begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q    <= '0;
			tick_out <= 1'h0;
		end else begin
			cnt_q    <= cnt_d;
			tick_out <= out_d;
		end
	end
endmodule : tick_div

module clock_select_divide
	import clkgen_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  osc_in_t   osc,
	input  wire logic cfg_wr,
	input  clk_cfg_t  cfg_wdata,
	input  wire logic wait_mode,
	input  wire logic stop_enter,
	input  wire logic stop_mode,
	output clk_cfg_t  cfg_q,
	output clk_out_t  clk,
	output clk_mode_t mode_q,
	output logic      internal_osc_usable,
	output logic      low_current_read_ok
);
	clk_cfg_t  cfg_d;
	clk_mode_t mode_d;
	ratio_t    cpu_ratio;
	ratio_t    fast_ratio;
	logic      main_ok;
	logic      sub_ok;
	logic      onchip_tick;
	logic      sys_tick;
	logic      cpu_run;
	logic      fi_run;
	logic      d128_src;
	logic      int_osc_d;
	logic      fast_tmr_d;
	logic      slow_int_d;
	logic      wdt_d;
	logic      usable_d;
	logic      lcr_d;
	logic      int_osc_q;
	logic      fast_tmr_q;
	logic      slow_int_q;
	logic      wdt_q;
	logic      cpu_tick;
	logic [4:0] fi_tick;
	logic      fast_div_tick;
	logic      d128_tick;

	// Control bits; stop entry wins over a same-cycle write
	always_comb begin
		cfg_d = cfg_q;
		if (cfg_wr) begin
			cfg_d = cfg_wdata;
		end
		if (stop_enter) begin
			cfg_d.cpu_div8_select = 1'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_q <= CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Source selection and mode decode
	always_comb begin
		main_ok = cfg_q.main_pin_mode && !cfg_q.main_osc_stop;
		sub_ok  = cfg_q.sub_pin_mode && !cfg_q.sub_osc_stop;
		if (cfg_q.fast_osc_select) begin
			onchip_tick = cfg_q.fast_osc_enable && osc.fast_osc_tick;
		end else begin
			onchip_tick = !cfg_q.slow_osc_off && osc.slow_osc_tick;
		end
		if (cfg_q.sub_clock_select) begin
			sys_tick = sub_ok && osc.sub_crystal_clock;
		end else if (!cfg_q.onchip_system_select) begin
			sys_tick = main_ok && osc.main_crystal_clock;
		end else begin
			sys_tick = onchip_tick;
		end
		if (!cfg_q.onchip_system_select && !cfg_q.sub_clock_select && main_ok) begin
			mode_d = MODE_HIGH_SPEED;
		end else if (cfg_q.sub_clock_select && sub_ok) begin
			mode_d = MODE_LOW_SPEED;
		end else if (cfg_q.onchip_system_select && !cfg_q.sub_clock_select
			&& cfg_q.fast_osc_enable && cfg_q.fast_osc_select) begin
			mode_d = MODE_FAST_ONCHIP;
		end else if (cfg_q.onchip_system_select && !cfg_q.sub_clock_select
			&& !cfg_q.slow_osc_off && !cfg_q.fast_osc_select) begin
			mode_d = MODE_SLOW_ONCHIP;
		end else begin
			mode_d = MODE_NONE;
		end
	end

	// CPU divide ratio; wake override is expected clear here
	always_comb begin
		if (cfg_q.cpu_div8_select) begin
			cpu_ratio = CPU_DIV8;
		end else begin
			case ({cfg_q.cpu_divider_field_hi, cfg_q.cpu_divider_field_lo})
				2'h0:    cpu_ratio = CPU_DIV1;
				2'h1:    cpu_ratio = CPU_DIV2;
				2'h2:    cpu_ratio = CPU_DIV4;
				default: cpu_ratio = CPU_DIV16;
			endcase
		end
		fast_ratio = FAST_DIV_BASE + DIV_W'(cfg_q.fast_osc_divider_reg);
		cpu_run    = !wait_mode && !stop_mode;
		fi_run     = !stop_mode && !(wait_mode && cfg_q.periph_clk_wait_stop);
	end

	// Low-current read window; the 3 kHz floor is software's to respect
	always_comb begin
		case (mode_d)
			MODE_LOW_SPEED:   lcr_d = cpu_ratio != CPU_DIV16;
			MODE_SLOW_ONCHIP: lcr_d = cpu_ratio >= CPU_DIV4;
			default:          lcr_d = 1'h0;
		endcase
	end

	tick_div #(.W(DIV_W)) u_cpu_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.tick_in  (sys_tick),
		.run      (cpu_run),
		.ratio    (cpu_ratio),
		.tick_out (cpu_tick)
	);

	for (genvar i = 0; i < 5; i++) begin : g_fi
		tick_div #(.W(DIV_W)) u_fi_div (
			.mclk     (mclk),
			.rst_n    (rst_n),
			.tick_in  (sys_tick),
			.run      (fi_run),
			.ratio    (FI_RATIO[i]),
			.tick_out (fi_tick[i])
		);
	end

	tick_div #(.W(DIV_W)) u_fast_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.tick_in  (osc.fast_osc_tick),
		.run      (cfg_q.fast_osc_enable && !stop_mode),
		.ratio    (fast_ratio),
		.tick_out (fast_div_tick)
	);

	tick_div #(.W(DIV_W)) u_d128_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.tick_in  (d128_src),
		.run      (!stop_mode),
		.ratio    (DIV128_RATIO),
		.tick_out (d128_tick)
	);

	// Undivided gated clocks; these all keep running in wait mode
	always_comb begin
		d128_src   = cfg_q.div128_source_select ? fast_div_tick : slow_int_q;
		int_osc_d  = onchip_tick && !stop_mode;
		fast_tmr_d = cfg_q.fast_osc_enable && osc.fast_osc_tick && !stop_mode;
		slow_int_d = !cfg_q.slow_osc_off && osc.slow_osc_tick && !stop_mode;
		wdt_d      = cfg_q.watchdog_source_protect && osc.slow_osc_tick;
		usable_d   = !cfg_q.slow_osc_off || cfg_q.fast_osc_enable;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			int_osc_q           <= 1'h0;
			fast_tmr_q          <= 1'h0;
			slow_int_q          <= 1'h0;
			wdt_q               <= 1'h0;
			internal_osc_usable <= 1'h0;
			low_current_read_ok <= 1'h0;
			mode_q              <= MODE_NONE;
		end else begin
			int_osc_q           <= int_osc_d;
			fast_tmr_q          <= fast_tmr_d;
			slow_int_q          <= slow_int_d;
			wdt_q               <= wdt_d;
			internal_osc_usable <= usable_d;
			low_current_read_ok <= lcr_d;
			mode_q              <= mode_d;
		end
	end

	// One driver for the whole output word
	assign clk = '{
		cpu_clock:                 cpu_tick,
		periph_divided_clock:      fi_tick,
		internal_osc_periph_clock: int_osc_q,
		fast_osc_timer_clock:      fast_tmr_q,
		fast_divided_clock:        fast_div_tick,
		slow_internal_clock:       slow_int_q,
		div128_capture_clock:      d128_tick,
		watchdog_dedicated_clock:  wdt_q
	};

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_STOP_SETS_DIV8: assert property (
		stop_enter |=> cfg_q.cpu_div8_select)
		else $error("stop entry did not set divide-by-8");

	AST_RESET_SLOW_UNDIV: assert property (
		$rose(rst_n) |-> cfg_q.onchip_system_select && !cfg_q.fast_osc_select
			&& !cfg_q.cpu_div8_select && !cfg_q.cpu_divider_field_hi
			&& !cfg_q.cpu_divider_field_lo && !cfg_q.slow_osc_off)
		else $error("reset state is not slow on-chip undivided");

	AST_DIV8_WINS: assert property (
		cfg_q.cpu_div8_select && cfg_q.cpu_divider_field_hi |-> cpu_ratio == CPU_DIV8)
		else $error("divide-by-8 did not override the field");

	AST_FI1_FOLLOWS: assert property (
		sys_tick && fi_run |=> clk.periph_divided_clock[0])
		else $error("f1 missed a system clock tick");

	AST_FI_WAIT_STOP: assert property (
		wait_mode && cfg_q.periph_clk_wait_stop ##1 wait_mode |-> clk.periph_divided_clock == '0)
		else $error("peripheral clock ran in wait with stop bit set");

	AST_FAST_GATED: assert property (
		!cfg_q.fast_osc_enable |=> !clk.fast_osc_timer_clock)
		else $error("fast timer clock ran while disabled");

	AST_FAST_IN_WAIT: assert property (
		cfg_q.fast_osc_enable && osc.fast_osc_tick && wait_mode && !stop_mode
			|=> clk.fast_osc_timer_clock)
		else $error("fast timer clock stopped in wait");

	AST_SLOW_GATED: assert property (
		cfg_q.slow_osc_off |=> !clk.slow_internal_clock)
		else $error("slow internal clock ran while off");

	AST_WDT_PROTECT: assert property (
		cfg_q.watchdog_source_protect && osc.slow_osc_tick |=> clk.watchdog_dedicated_clock)
		else $error("watchdog clock missed a tick under protect");

	AST_FAST_ONCHIP: assert property (
		cfg_q.onchip_system_select && !cfg_q.sub_clock_select && cfg_q.fast_osc_enable
			&& cfg_q.fast_osc_select && osc.fast_osc_tick && fi_run
			|=> clk.periph_divided_clock[0])
		else $error("fast oscillator not used as on-chip clock");

	AST_MAIN_GATED: assert property (
		!cfg_q.onchip_system_select && !cfg_q.sub_clock_select && cfg_q.main_osc_stop
			|-> !sys_tick)
		else $error("stopped main crystal reached system clock");

	AST_USABLE: assert property (
		cfg_q.fast_osc_enable |=> internal_osc_usable)
		else $error("timer clock not usable with fast enabled");

	COV_STOP: cover property (stop_enter ##1 stop_mode);
	COV_HIGH_SPEED: cover property (mode_q == MODE_HIGH_SPEED && clk.cpu_clock);
	COV_D128: cover property (clk.div128_capture_clock);
	COV_LCR: cover property (low_current_read_ok && mode_q == MODE_LOW_SPEED);

endmodule : clock_select_divide

// *** pkg/clkgen_pkg.sv ***
// Package for the system clock select and divide block.
// Assumes oscillator edges arrive as one-cycle ticks synchronous to mclk.
package clkgen_pkg;

	// Software control bits, held by the block
	typedef struct packed {
		logic       onchip_system_select;
		logic       sub_clock_select;
		logic       main_pin_mode;
		logic       main_osc_stop;
		logic       sub_pin_mode;
		logic       sub_osc_stop;
		logic       slow_osc_off;
		logic       fast_osc_enable;
		logic       fast_osc_select;
		logic       div128_source_select;
		logic       periph_clk_wait_stop;
		logic       wake_clock_override;
		logic       watchdog_source_protect;
		logic       cpu_div8_select;
		logic       cpu_divider_field_hi;
		logic       cpu_divider_field_lo;
		logic [2:0] fast_osc_divider_reg;
	} clk_cfg_t;

	// Oscillator edge ticks
	typedef struct packed {
		logic main_crystal_clock;
		logic sub_crystal_clock;
		logic fast_osc_tick;
		logic slow_osc_tick;
	} osc_in_t;

	// Derived clock ticks
	typedef struct packed {
		logic       cpu_clock;
		logic [4:0] periph_divided_clock;
		logic       internal_osc_periph_clock;
		logic       fast_osc_timer_clock;
		logic       fast_divided_clock;
		logic       slow_internal_clock;
		logic       div128_capture_clock;
		logic       watchdog_dedicated_clock;
	} clk_out_t;

	typedef enum logic [2:0] {
		MODE_HIGH_SPEED,
		MODE_LOW_SPEED,
		MODE_FAST_ONCHIP,
		MODE_SLOW_ONCHIP,
		MODE_NONE
	} clk_mode_t;

	localparam int DIV_W = 8;
	typedef logic [DIV_W-1:0] ratio_t;

	// Slow on-chip source, undivided; main and sub oscillators stopped
	localparam clk_cfg_t CFG_RST = '{
		onchip_system_select: 1'h1,
		main_osc_stop:        1'h1,
		sub_osc_stop:         1'h1,
		default:              '0
	};

	localparam ratio_t CPU_DIV1  = 8'h01;
	localparam ratio_t CPU_DIV2  = 8'h02;
	localparam ratio_t CPU_DIV4  = 8'h04;
	localparam ratio_t CPU_DIV8  = 8'h08;
	localparam ratio_t CPU_DIV16 = 8'h10;
	localparam ratio_t FI_RATIO [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
	localparam ratio_t FAST_DIV_BASE = 8'h02;
	localparam ratio_t DIV128_RATIO  = 8'h80;

endpackage : clkgen_pkg

// *** dv/tb_top.sv ***
// Self-checking bench for the clock select and divide block.
// Assumes oscillator edges are one-cycle ticks; inputs change at the falling edge.
`timescale 1ns/1ps

module tb_top
	import clkgen_pkg::*;
;
	localparam osc_in_t T_SLOW = 4'h1;
	localparam osc_in_t T_FAST = 4'h2;
	localparam osc_in_t T_SUB  = 4'h4;
	localparam osc_in_t T_MAIN = 4'h8;

	logic      mclk;
	logic      rst_n;
	osc_in_t   osc;
	logic      cfg_wr;
	clk_cfg_t  cfg_wdata;
	logic      wait_mode;
	logic      stop_enter;
	logic      stop_mode;
	clk_cfg_t  cfg_q;
	clk_out_t  clk;
	clk_mode_t mode_q;
	logic      internal_osc_usable;
	logic      low_current_read_ok;
	int        error_cnt;
	int        samples_checked;
	integer    n_cpu, n_io, n_ft, n_fd, n_si, n_d128, n_wd;
	integer    n_fi [5];
	logic      cnt_clr;

	clock_select_divide clock_select_divide_inst (
		.mclk(mclk), .rst_n(rst_n), .osc(osc), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.wait_mode(wait_mode), .stop_enter(stop_enter), .stop_mode(stop_mode), .cfg_q(cfg_q),
		.clk(clk), .mode_q(mode_q), .internal_osc_usable(internal_osc_usable),
		.low_current_read_ok(low_current_read_ok)
	);

	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	// Pulse counters for every derived clock; four-state so an unknown output shows
	always @(posedge mclk) begin
		if (cnt_clr) begin
			n_cpu = 0;
			n_io = 0;
			n_ft = 0;
			n_fd = 0;
			n_si = 0;
			n_d128 = 0;
			n_wd = 0;
			n_fi = '{0, 0, 0, 0, 0};
		end else if (rst_n) begin
			n_cpu += 32'(clk.cpu_clock);
			for (int k = 0; k < 5; k++) n_fi[k] += 32'(clk.periph_divided_clock[k]);
			n_io += 32'(clk.internal_osc_periph_clock);
			n_ft += 32'(clk.fast_osc_timer_clock);
			n_fd += 32'(clk.fast_divided_clock);
			n_si += 32'(clk.slow_internal_clock);
			n_d128 += 32'(clk.div128_capture_clock);
			n_wd += 32'(clk.watchdog_dedicated_clock);
		end
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task complete_run;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task do_reset;
		rst_n = 1'b0;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
	endtask : do_reset

	task wr(input clk_cfg_t c);
		cfg_wdata = c;
		cfg_wr = 1'b1;
		@(negedge mclk);
		cfg_wr = 1'b0;
	endtask : wr

	// Drive n ticks of one oscillator, counting what comes out
	task ticks(input int n, input osc_in_t t);
		cnt_clr = 1'b1;
		repeat (n) begin
			osc = t;
			@(negedge mclk);
			cnt_clr = 1'b0;
		end
		osc = '0;
		repeat (3) @(negedge mclk);
	endtask : ticks

	task t_reset;
		do_reset;
		@(negedge mclk);
		check("cfg", cfg_q, CFG_RST);
		check("mode", mode_q, MODE_SLOW_ONCHIP);
		check("usable", internal_osc_usable, 1'h1);
		check("lcr", low_current_read_ok, 1'h0);
	endtask : t_reset

	task t_cpu_ratio;
		clk_cfg_t c;
		int       r;
		for (int i = 0; i < 5; i++) begin
			c = CFG_RST;
			{c.cpu_divider_field_hi, c.cpu_divider_field_lo} = (i == 4) ? 2'h3 : i[1:0];
			c.cpu_div8_select = (i == 4);
			r = (i == 4) ? 8 : (i == 3) ? 16 : (1 << i);
			do_reset;
			wr(c);
			ticks(160, T_SLOW);
			check("cpu", n_cpu, 160 / r);
			check("lcr", low_current_read_ok, r >= 4);
			check("fi0", n_fi[0], 160);
			check("fi1", n_fi[1], 80);
			check("fi2", n_fi[2], 40);
			check("fi3", n_fi[3], 20);
			check("fi4", n_fi[4], 5);
		end
	endtask : t_cpu_ratio

	task t_modes;
		clk_cfg_t c;
		do_reset;
		c = CFG_RST;
		c.onchip_system_select = 1'h0;
		c.main_pin_mode = 1'h1;
		c.main_osc_stop = 1'h0;
		c.cpu_divider_field_lo = 1'h1;
		wr(c);
		ticks(32, T_MAIN);
		check("cpu main", n_cpu, 16);
		check("mode", mode_q, MODE_HIGH_SPEED);
		check("fi4 main", n_fi[4], 1);
		do_reset;
		c = CFG_RST;
		c.sub_clock_select = 1'h1;
		c.sub_pin_mode = 1'h1;
		c.sub_osc_stop = 1'h0;
		c.cpu_div8_select = 1'h1;
		wr(c);
		ticks(32, T_SUB);
		check("cpu sub", n_cpu, 4);
		check("mode", mode_q, MODE_LOW_SPEED);
		check("lcr", low_current_read_ok, 1'h1);
		do_reset;
		c = CFG_RST;
		c.fast_osc_enable = 1'h1;
		c.fast_osc_select = 1'h1;
		c.fast_osc_divider_reg = 3'h7;
		wr(c);
		ticks(36, T_FAST);
		check("cpu fast", n_cpu, 36);
		check("mode", mode_q, MODE_FAST_ONCHIP);
		check("ftimer", n_ft, 36);
		check("fdiv", n_fd, 4);
		check("iosc", n_io, 36);
		c.fast_osc_enable = 1'h0;
		wr(c);
		ticks(36, T_FAST);
		check("ftimer off", n_ft, 0);
		check("fdiv off", n_fd, 0);
		check("mode", mode_q, MODE_NONE);
	endtask : t_modes

	task t_wait;
		clk_cfg_t c;
		do_reset;
		c = CFG_RST;
		c.periph_clk_wait_stop = 1'h1;
		wr(c);
		wait_mode = 1'b1;
		ticks(32, T_SLOW);
		check("cpu wait", n_cpu, 0);
		check("fi0 wait", n_fi[0], 0);
		check("iosc wait", n_io, 32);
		check("slow wait", n_si, 32);
		c.periph_clk_wait_stop = 1'h0;
		wr(c);
		ticks(32, T_SLOW);
		check("fi1 wait", n_fi[1], 16);
		wait_mode = 1'b0;
		c.slow_osc_off = 1'h1;
		wr(c);
		ticks(16, T_SLOW);
		check("slow off", n_si, 0);
		check("cpu off", n_cpu, 0);
		check("usable", internal_osc_usable, 1'h0);
	endtask : t_wait

	task t_div128;
		clk_cfg_t c;
		do_reset;
		ticks(256, T_SLOW);
		check("d128 slow", n_d128, 2);
		c = CFG_RST;
		c.div128_source_select = 1'h1;
		c.fast_osc_enable = 1'h1;
		wr(c);
		ticks(512, T_FAST);
		check("fdiv2", n_fd, 256);
		check("d128 fast", n_d128, 2);
	endtask : t_div128

	task t_wdt_stop;
		clk_cfg_t c;
		do_reset;
		c = CFG_RST;
		c.watchdog_source_protect = 1'h1;
		wr(c);
		stop_mode = 1'b1;
		ticks(16, T_SLOW);
		check("wdt stop", n_wd, 16);
		check("cpu stop", n_cpu, 0);
		stop_mode = 1'b0;
		c.watchdog_source_protect = 1'h0;
		c.cpu_divider_field_lo = 1'h1;
		c.wake_clock_override = 1'h0;
		wr(c);
		ticks(16, T_SLOW);
		check("wdt off", n_wd, 0);
		cfg_wdata = c;
		cfg_wr = 1'b1;
		stop_enter = 1'b1;
		@(negedge mclk);
		cfg_wr = 1'b0;
		stop_enter = 1'b0;
		check("div8 stop", cfg_q.cpu_div8_select, 1'h1);
		check("field", cfg_q.cpu_divider_field_lo, 1'h1);
		@(negedge mclk);
		wr(c);
		check("div8 clr", cfg_q.cpu_div8_select, 1'h0);
		stop_enter = 1'b1;
		@(negedge mclk);
		stop_enter = 1'b0;
		stop_mode = 1'b1;
		check("div8 set", cfg_q.cpu_div8_select, 1'h1);
		@(negedge mclk);
		stop_mode = 1'b0;
	endtask : t_wdt_stop

	initial begin
		error_cnt = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		osc = '0;
		cfg_wr = 1'b0;
		cnt_clr = 1'b0;
		cfg_wdata = CFG_RST;
		wait_mode = 1'b0;
		stop_enter = 1'b0;
		stop_mode = 1'b0;
		t_reset;
		t_cpu_ratio;
		t_modes;
		t_wait;
		t_div128;
		t_wdt_stop;
		complete_run;
	end

	// Cut a hang short
	initial begin
		#400us;
		error_cnt++;
		complete_run;
	end
endmodule : tb_top
